// ==== t8w_defines.vh ====
// Constants shared by the 8-bit waveform timer files.
`ifndef T8W_DEFINES_VH
`define T8W_DEFINES_VH
// Register byte offsets on the AHB-Lite bus.
`define T8W_OFF_CTRL 8'h00
`define T8W_OFF_ACT 8'h04
`define T8W_OFF_CMPA 8'h08
`define T8W_OFF_CMPB 8'h0C
`define T8W_OFF_COUNT 8'h10
`define T8W_OFF_FLAGS 8'h14
// Control register fields.
`define T8W_MODE_LSB 0
`define T8W_CSEL_LSB 4
`define T8W_ASYNC_BIT 8
// Action register fields.
`define T8W_ACTA_LSB 0
`define T8W_ACTB_LSB 2
`define T8W_DIRA_BIT 4
`define T8W_DIRB_BIT 5
`define T8W_PORTA_BIT 6
`define T8W_PORTB_BIT 7
// Flag register fields.
`define T8W_OVF_BIT 0
`define T8W_CFA_BIT 1
`define T8W_CFB_BIT 2
// Waveform mode codes.
`define T8W_MODE_PCFF 3'h1
`define T8W_MODE_CTC 3'h2
`define T8W_MODE_FASTFF 3'h3
`define T8W_MODE_PCCMP 3'h5
`define T8W_MODE_FASTCMP 3'h7
// Mode classes seen by a compare channel.
`define T8W_CLS_NORM 2'h0
`define T8W_CLS_FAST 2'h1
`define T8W_CLS_PC 2'h2
// Counter extremes and reset values.
`define T8W_MAX 8'hFF
`define T8W_BOTTOM 8'h00
`define T8W_RST_BYTE 8'h00
`endif

// ==== t8w_prescaler.v ====
// Prescaler that turns the source clock into timer ticks.
`timescale 1ns/10ps
module t8w_prescaler (
  input wire ref_clk_in,
  input wire reset_in,
  input wire src_tick_in,
  input wire [2:0] csel_in,
  output wire tick_out
);
  // Free-running divider that advances on each source tick.
  reg [9:0] div_q;
  // Mask of divider bits that must all be one for a tick.
  reg [9:0] mask;

  // Select the division factor: stop, 1, 8, 32, 64, 128, 256 or 1024.
  always @* begin
    case (csel_in)
      3'h1: mask = 10'h000;
      3'h2: mask = 10'h007;
      3'h3: mask = 10'h01F;
      3'h4: mask = 10'h03F;
      3'h5: mask = 10'h07F;
      3'h6: mask = 10'h0FF;
      3'h7: mask = 10'h3FF;
      default: mask = 10'h000;
    endcase
  end

  // Count source ticks; the divider wraps by itself.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      div_q <= 10'h000;
    end else if (src_tick_in) begin
      div_q <= div_q + 10'h001;
    end
  end

  // A tick fires when every selected divider bit is one.
  assign tick_out = src_tick_in && (csel_in != 3'h0) && ((div_q & mask) == mask);
endmodule

// ==== t8w_chan.v ====
// One compare channel: compare buffer and waveform state.
`timescale 1ns/10ps
`include "t8w_defines.vh"
module t8w_chan (
  input wire ref_clk_in,
  input wire reset_in,
  input wire tick_in,
  input wire [1:0] cls_in,
  input wire [7:0] count_in,
  input wire [7:0] top_in,
  input wire up_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  input wire [1:0] action_in,
  output wire [7:0] cmp_buf_out,
  output wire [7:0] cmp_out,
  output wire match_out,
  output wire wave_out
);
  // Buffered compare value that software writes.
  reg [7:0] cmp_buf_q;
  // Live compare value that the comparator uses.
  reg [7:0] cmp_q;
  // Internal waveform state before the pin logic.
  reg wave_q;
  // Result of a clear action for this polarity; set is its inverse.
  wire up_res;
  // Counter sits at the top of its range.
  wire at_top;
  // Counter sits at the bottom of its range.
  wire at_bot;

  assign match_out = (count_in == cmp_q);
  assign cmp_buf_out = cmp_buf_q;
  assign cmp_out = cmp_q;
  assign wave_out = wave_q;
  assign at_top = (count_in == top_in);
  assign at_bot = (count_in == `T8W_BOTTOM);
  // Action two clears on the up match, action three sets on it.
  assign up_res = (action_in == 2'h3);

  // Buffer writes; the live compare reloads at the top in PWM modes.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      cmp_buf_q <= `T8W_RST_BYTE;
      cmp_q <= `T8W_RST_BYTE;
    end else begin
      if (wr_in) begin
        cmp_buf_q <= wdata_in;
      end
      if (cls_in == `T8W_CLS_NORM) begin
        // No double buffering outside PWM; writes act at once.
        if (wr_in) begin
          cmp_q <= wdata_in;
        end
      end else if (tick_in && at_top) begin
        // PWM modes take the buffered value at the top.
        cmp_q <= cmp_buf_q;
      end
    end
  end

  // Waveform state update on each timer tick.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      wave_q <= 1'b0;
    end else if (tick_in && (action_in != 2'h0)) begin
      case (cls_in)
        `T8W_CLS_FAST: begin
          if (action_in == 2'h1) begin
            // Toggle on each match for a square wave.
            if (match_out) begin
              wave_q <= ~wave_q;
            end
          end else if (at_top) begin
            // Leaving the top restarts the period; this wins over a match
            // so a compare at the maximum holds a constant level.
            wave_q <= ~up_res;
          end else if (match_out) begin
            // Match clears for action two and sets for action three.
            wave_q <= up_res;
          end
        end
        `T8W_CLS_PC: begin
          if (action_in != 2'h1) begin
            if (match_out && at_top) begin
              // A compare at the top acts like a down match.
              wave_q <= ~up_res;
            end else if (match_out && at_bot) begin
              // A compare at the bottom acts like an up match.
              wave_q <= up_res;
            end else if (match_out) begin
              // Up match gives the clear side, down match the set side.
              wave_q <= up_in ? up_res : ~up_res;
            end else if (at_bot && !up_in) begin
              // Period start realigns to the down-match level for symmetry.
              wave_q <= ~up_res;
            end
          end
        end
        default: begin
          if (match_out) begin
            case (action_in)
              2'h1: wave_q <= ~wave_q;
              2'h2: wave_q <= 1'b0;
              default: wave_q <= 1'b1;
            endcase
          end
        end
      endcase
    end
  end
endmodule

// ==== t8w_top.v ====
// Top of the 8-bit timer with waveform modes and an AHB-Lite slave.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "t8w_defines.vh"
// What this block does
// - Clear-on-match mode clears counter at compare A.
// - Clear-on-match sets compare A flag at ceiling.
// - Clear-on-match compare A unbuffered; late write wraps.
// - Clear-on-match action one toggles output A.
// - Pin driven only when direction bit selects output.
// - Clear-on-match overflow flag on maximum to zero.
// - Counter advances on prescaled ticks, selectable divisor.
// - Fast PWM counts zero to ceiling, restarts.
// - Fast PWM clears counter tick after ceiling.
// - Fast PWM actions two/three: match and bottom.
// - Fast PWM overflow flag at ceiling.
// - Fast PWM extremes: spike or constant level.
// - Fast PWM action one toggles; compare buffered.
// - Phase-correct counts up then down repeatedly.
// - Phase-correct holds ceiling exactly one tick.
// - Phase-correct actions two/three by count direction.
// - Phase-correct overflow flag at zero.
// - Phase-correct extremes give constant levels.
// - Phase-correct period-start transition without match.
// - Periods at 0xFF ceiling: 510 ticks dual slope, 256 single.
// - Tick enables clock; oscillator tick replaces source.
// - Compare flag set on tick after equality.
// - Action zero leaves output; pin keeps port.
module t8w_top (
  input wire ref_clk_in,
  input wire reset_in,
  input wire osc_tick_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  output reg wave_a_out,
  output reg wave_a_oe_n_out,
  output reg wave_b_out,
  output reg wave_b_oe_n_out
);
  // Control register: mode, clock select, oscillator select.
  reg [2:0] wave_mode_sel_q;
  reg [2:0] csel_q;
  reg async_q;
  // Action register: output actions, pin directions, port values.
  reg [1:0] out_action_a_q;
  reg [1:0] out_action_b_q;
  reg dir_a_q;
  reg dir_b_q;
  reg port_a_q;
  reg port_b_q;
  // Counter, its direction and the sticky flags.
  reg [7:0] counter_value_q;
  reg [7:0] counter_value_d;
  reg up_q;
  reg up_d;
  reg overflow_flag_q;
  reg compare_a_flag_q;
  reg compare_b_flag_q;
  // Pending data phase of an accepted write.
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  // Decoded mode information.
  reg [1:0] cls;
  reg [7:0] top_val;
  reg ovf_hit;
  reg [31:0] rd_mux;
  // Timer tick and source tick.
  wire src_tick;
  wire timer_tick;
  // Address phase accepted this cycle.
  wire acc;
  // Write strobes for each register in the data phase.
  wire wr_ctrl;
  wire wr_act;
  wire wr_cmpa;
  wire wr_cmpb;
  wire wr_count;
  wire wr_flags;
  // Channel outputs.
  wire [7:0] compare_a_buf;
  wire [7:0] compare_a;
  wire [7:0] compare_b_buf;
  wire [7:0] compare_b;
  wire match_a;
  wire match_b;
  wire wave_a;
  wire wave_b;

  // The oscillator tick stands in for the clock in async operation.
  assign src_tick = async_q ? osc_tick_in : 1'b1;

  // Prescaler makes the timer tick used as a clock enable.
  t8w_prescaler u_presc (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .src_tick_in(src_tick),
    .csel_in(csel_q),
    .tick_out(timer_tick)
  );

  // Bus decode of the address and data phases.
  assign acc = hsel_in && htrans_in[1] && hready_in;
  assign wr_ctrl = wr_pend_q && (wr_addr_q == `T8W_OFF_CTRL);
  assign wr_act = wr_pend_q && (wr_addr_q == `T8W_OFF_ACT);
  assign wr_cmpa = wr_pend_q && (wr_addr_q == `T8W_OFF_CMPA);
  assign wr_cmpb = wr_pend_q && (wr_addr_q == `T8W_OFF_CMPB);
  assign wr_count = wr_pend_q && (wr_addr_q == `T8W_OFF_COUNT);
  assign wr_flags = wr_pend_q && (wr_addr_q == `T8W_OFF_FLAGS);

  // Classify the mode and pick the counting ceiling.
  always @* begin
    case (wave_mode_sel_q)
      `T8W_MODE_CTC: begin
        cls = `T8W_CLS_NORM;
        top_val = compare_a;
      end
      `T8W_MODE_FASTFF: begin
        cls = `T8W_CLS_FAST;
        top_val = `T8W_MAX;
      end
      `T8W_MODE_FASTCMP: begin
        cls = `T8W_CLS_FAST;
        top_val = compare_a;
      end
      `T8W_MODE_PCFF: begin
        cls = `T8W_CLS_PC;
        top_val = `T8W_MAX;
      end
      `T8W_MODE_PCCMP: begin
        cls = `T8W_CLS_PC;
        top_val = compare_a;
      end
      default: begin
        cls = `T8W_CLS_NORM;
        top_val = `T8W_MAX;
      end
    endcase
  end

  // Next count and direction for one timer tick.
  always @* begin
    counter_value_d = counter_value_q + 8'h01;
    up_d = 1'b1;
    ovf_hit = 1'b0;
    case (cls)
      `T8W_CLS_FAST: begin
        // Ceiling reached: overflow now, zero on this tick.
        if (counter_value_q == top_val) begin
          counter_value_d = `T8W_BOTTOM;
          ovf_hit = 1'b1;
        end
      end
      `T8W_CLS_PC: begin
        // Dual slope; 0xFF ceiling gives a 510-tick period.
        if (counter_value_q == `T8W_BOTTOM) begin
          ovf_hit = 1'b1;
        end
        if (up_q) begin
          if (counter_value_q == top_val) begin
            // The ceiling lasts one tick, then the count goes down.
            counter_value_d = counter_value_q - 8'h01;
            up_d = 1'b0;
          end
        end else if (counter_value_q != `T8W_BOTTOM) begin
          counter_value_d = counter_value_q - 8'h01;
          up_d = 1'b0;
        end
      end
      default: begin
        // Passing the maximum wraps to zero and marks overflow.
        if (counter_value_q == `T8W_MAX) begin
          ovf_hit = 1'b1;
        end
        // Clear-on-match resets at compare A; a missed one wraps.
        if ((wave_mode_sel_q == `T8W_MODE_CTC) && match_a) begin
          counter_value_d = `T8W_BOTTOM;
        end
      end
    endcase
  end

  // Counter register; a bus write overrides the tick.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      counter_value_q <= `T8W_RST_BYTE;
      up_q <= 1'b1;
    end else if (wr_count) begin
      counter_value_q <= hwdata_in[7:0];
    end else if (timer_tick) begin
      counter_value_q <= counter_value_d;
      up_q <= up_d;
    end
  end

  // Compare channel A, which also sets the ceiling.
  t8w_chan u_chan_a (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .tick_in(timer_tick),
    .cls_in(cls),
    .count_in(counter_value_q),
    .top_in(top_val),
    .up_in(up_q),
    .wr_in(wr_cmpa),
    .wdata_in(hwdata_in[7:0]),
    .action_in(out_action_a_q),
    .cmp_buf_out(compare_a_buf),
    .cmp_out(compare_a),
    .match_out(match_a),
    .wave_out(wave_a)
  );

  // Compare channel B.
  t8w_chan u_chan_b (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .tick_in(timer_tick),
    .cls_in(cls),
    .count_in(counter_value_q),
    .top_in(top_val),
    .up_in(up_q),
    .wr_in(wr_cmpb),
    .wdata_in(hwdata_in[7:0]),
    .action_in(out_action_b_q),
    .cmp_buf_out(compare_b_buf),
    .cmp_out(compare_b),
    .match_out(match_b),
    .wave_out(wave_b)
  );

  // Sticky flags; a set in the same cycle beats a write-one clear.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      overflow_flag_q <= 1'b0;
      compare_a_flag_q <= 1'b0;
      compare_b_flag_q <= 1'b0;
    end else begin
      if (timer_tick && ovf_hit) begin
        overflow_flag_q <= 1'b1;
      end else if (wr_flags && hwdata_in[`T8W_OVF_BIT]) begin
        overflow_flag_q <= 1'b0;
      end
      if (timer_tick && match_a) begin
        compare_a_flag_q <= 1'b1;
      end else if (wr_flags && hwdata_in[`T8W_CFA_BIT]) begin
        compare_a_flag_q <= 1'b0;
      end
      if (timer_tick && match_b) begin
        compare_b_flag_q <= 1'b1;
      end else if (wr_flags && hwdata_in[`T8W_CFB_BIT]) begin
        compare_b_flag_q <= 1'b0;
      end
    end
  end

  // Control and action registers written in the data phase.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      wave_mode_sel_q <= 3'h0;
      csel_q <= 3'h0;
      async_q <= 1'b0;
      out_action_a_q <= 2'h0;
      out_action_b_q <= 2'h0;
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
      port_a_q <= 1'b0;
      port_b_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        wave_mode_sel_q <= hwdata_in[`T8W_MODE_LSB +: 3];
        csel_q <= hwdata_in[`T8W_CSEL_LSB +: 3];
        async_q <= hwdata_in[`T8W_ASYNC_BIT];
      end
      if (wr_act) begin
        // Actions take effect at once, not with the compare buffer.
        out_action_a_q <= hwdata_in[`T8W_ACTA_LSB +: 2];
        out_action_b_q <= hwdata_in[`T8W_ACTB_LSB +: 2];
        dir_a_q <= hwdata_in[`T8W_DIRA_BIT];
        dir_b_q <= hwdata_in[`T8W_DIRB_BIT];
        port_a_q <= hwdata_in[`T8W_PORTA_BIT];
        port_b_q <= hwdata_in[`T8W_PORTB_BIT];
      end
    end
  end

  // Read multiplexer, indexed by the address-phase address.
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr_in[7:0])
      `T8W_OFF_CTRL: begin
        rd_mux[`T8W_MODE_LSB +: 3] = wave_mode_sel_q;
        rd_mux[`T8W_CSEL_LSB +: 3] = csel_q;
        rd_mux[`T8W_ASYNC_BIT] = async_q;
      end
      `T8W_OFF_ACT: begin
        rd_mux[`T8W_ACTA_LSB +: 2] = out_action_a_q;
        rd_mux[`T8W_ACTB_LSB +: 2] = out_action_b_q;
        rd_mux[`T8W_DIRA_BIT] = dir_a_q;
        rd_mux[`T8W_DIRB_BIT] = dir_b_q;
        rd_mux[`T8W_PORTA_BIT] = port_a_q;
        rd_mux[`T8W_PORTB_BIT] = port_b_q;
      end
      `T8W_OFF_CMPA: rd_mux[7:0] = compare_a_buf;
      `T8W_OFF_CMPB: rd_mux[7:0] = compare_b_buf;
      `T8W_OFF_COUNT: rd_mux[7:0] = counter_value_q;
      `T8W_OFF_FLAGS: begin
        rd_mux[`T8W_OVF_BIT] = overflow_flag_q;
        rd_mux[`T8W_CFA_BIT] = compare_a_flag_q;
        rd_mux[`T8W_CFB_BIT] = compare_b_flag_q;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend_q <= acc && hwrite_in;
      if (acc) begin
        wr_addr_q <= haddr_in[7:0];
      end
      // Read data are registered so they stand in the data phase.
      if (acc && !hwrite_in) begin
        hrdata_out <= rd_mux;
      end
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // Pin drivers: waveform or port value, enabled by direction.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      wave_a_out <= 1'b0;
      wave_b_out <= 1'b0;
      wave_a_oe_n_out <= 1'b1;
      wave_b_oe_n_out <= 1'b1;
    end else begin
      // Action zero keeps the ordinary port value on the pin.
      wave_a_out <= (out_action_a_q != 2'h0) ? wave_a : port_a_q;
      wave_b_out <= (out_action_b_q != 2'h0) ? wave_b : port_b_q;
      // Driven only while the direction bit selects output.
      wave_a_oe_n_out <= ~dir_a_q;
      wave_b_oe_n_out <= ~dir_b_q;
    end
  end
endmodule

// ==== t8w_monitor.sv ====
// Assertion checker that watches the ports of the waveform timer top.
`timescale 1ns/10ps
module t8w_monitor (
  input wire ref_clk_in,
  input wire reset_in,
  input wire osc_tick_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire wave_a_out,
  input wire wave_a_oe_n_out,
  input wire wave_b_out,
  input wire wave_b_oe_n_out
);
  // An address phase accepted by the slave.
  wire acc = hsel_in & htrans_in[1] & hready_in;
  // An accepted read address phase.
  wire rd_acc = acc & ~hwrite_in;
  // Marks a write data phase and remembers its offset.
  reg wph_q;
  reg [7:0] wad_q;
  // Copy of the action register, kept so pin controls can be predicted.
  reg [7:0] act_q;
  // Follows bus writes into the action register.
  always @(posedge ref_clk_in) begin
    wph_q <= ~reset_in & acc & hwrite_in;
    wad_q <= haddr_in[7:0];
    if (reset_in) begin
      act_q <= 8'h00;
    end else if (wph_q && wad_q == 8'h04) begin
      act_q <= hwdata_in[7:0];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
    else $error("slave not ready or response not OKAY");
  AST_OE_A: assert property (wave_a_oe_n_out == ~$past(act_q[4]))
    else $error("pin A enable does not follow its direction bit");
  AST_OE_B: assert property (wave_b_oe_n_out == ~$past(act_q[5]))
    else $error("pin B enable does not follow its direction bit");
  AST_PORT_A: assert property ($past(act_q[1:0]) == 2'h0 |-> wave_a_out == $past(act_q[6]))
    else $error("pin A does not show its port value");
  AST_PORT_B: assert property ($past(act_q[3:2]) == 2'h0 |-> wave_b_out == $past(act_q[7]))
    else $error("pin B does not show its port value");
  AST_RD_UNMAP: assert property (rd_acc && haddr_in[7:0] > 8'h14 |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_ACT: assert property (rd_acc && haddr_in[7:0] == 8'h04
    |=> hrdata_out == {24'h0, $past(act_q)})
    else $error("action register read differs from value written");
  AST_RD_FLAGS: assert property (rd_acc && haddr_in[7:0] == 8'h14 |=> hrdata_out[31:3] == 29'h0)
    else $error("flag register unused bits not zero");
  AST_HOLD: assert property (!rd_acc |=> $stable(hrdata_out))
    else $error("read data changed without a read");
endmodule

// ==== t8w_load.sv ====
// Model of the load on one waveform pin: measures period and high time.
`timescale 1ns/10ps
module t8w_load (
  input wire ref_clk_in,
  input wire clr_in,
  input wire wave_in,
  input wire oe_n_in,
  output reg [15:0] period_out,
  output reg [15:0] high_out,
  output wire level_out
);
  // An undriven pin is pulled low by the load.
  assign level_out = oe_n_in ? 1'b0 : wave_in;
  // Previous level, cycles since the last rise, length of the current high.
  reg prev_q;
  reg [15:0] since_q;
  reg [15:0] hcnt_q;
  reg [1:0] rises_q;
  // Measures rise-to-rise period and the width of each high pulse.
  always @(posedge ref_clk_in) begin
    prev_q <= level_out;
    hcnt_q <= level_out ? hcnt_q + 16'h1 : 16'h0;
    since_q <= since_q + 16'h1;
    if (clr_in) begin
      period_out <= 16'h0;
      high_out <= 16'h0;
      rises_q <= 2'h0;
      hcnt_q <= 16'h0;
    end else begin
      // A rise closes one period once a first rise has been seen.
      if (level_out && !prev_q) begin
        since_q <= 16'h1;
        if (rises_q != 2'h0) period_out <= since_q;
        if (rises_q != 2'h3) rises_q <= rises_q + 2'h1;
      end
      // A fall closes one high pulse.
      if (!level_out && prev_q) high_out <= hcnt_q;
    end
  end
endmodule

// ==== tb_timer8_waveform_modes.sv ====
// Self-checking testbench for the 8-bit waveform timer.
`timescale 1ns/10ps
`include "t8w_defines.vh"
module tb_timer8_waveform_modes;
  // One waveform case: mode, compares, action, expected period and high (or level).
  typedef struct {logic [2:0] m; logic [7:0] ca, cb, act; int pa, ha, pb, hb;} t8w_row_t;
  reg ref_clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg osc_tick_in = 1'b0;
  reg hsel_in = 1'b0;
  reg [31:0] haddr_in = 32'h0;
  reg [1:0] htrans_in = 2'h0;
  reg hwrite_in = 1'b0;
  reg [2:0] hsize_in = 3'h2;
  reg [31:0] hwdata_in = 32'h0;
  reg clr = 1'b0;
  reg [1:0] ocnt = 2'h0;
  wire hready_in;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, wave_a_out, wave_a_oe_n_out, wave_b_out, wave_b_oe_n_out;
  wire [15:0] per_a, per_b, hi_a, hi_b;
  wire lvl_a, lvl_b;
  integer errors = 0;
  integer compares = 0;
  integer i;
  logic [31:0] rd;
  t8w_row_t rows [0:7];
  integer pexp [0:6] = '{160, 40, 20, 10, 5, 1, 40};
  // The single slave's ready is the bus ready.
  assign hready_in = hreadyout_out;
  // 10 MHz clock.
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // Oscillator tick on every fourth clock.
  always @(posedge ref_clk_in) begin
    ocnt <= ocnt + 2'h1;
    osc_tick_in <= &ocnt;
  end
  t8w_top u_dut (.ref_clk_in, .reset_in, .osc_tick_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .wave_a_out, .wave_a_oe_n_out, .wave_b_out, .wave_b_oe_n_out);
  t8w_load u_load_a (.ref_clk_in, .clr_in(clr), .wave_in(wave_a_out),
    .oe_n_in(wave_a_oe_n_out), .period_out(per_a), .high_out(hi_a), .level_out(lvl_a));
  t8w_load u_load_b (.ref_clk_in, .clr_in(clr), .wave_in(wave_b_out),
    .oe_n_in(wave_b_oe_n_out), .period_out(per_b), .high_out(hi_b), .level_out(lvl_b));
  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Waits for ready under a bound; a hang ends the run.
  task wait_rdy;
    integer n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n = n + 1;
    end while (hreadyout_out !== 1'b1 && n < 20);
    if (hreadyout_out !== 1'b1) begin
      errors = errors + 1;
      test_done;
    end
  endtask
  // One single AHB-Lite word transfer; read data is taken at the data phase edge.
  task bus(input [7:0] a, input w, input [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    htrans_in <= 2'h2;
    wait_rdy;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy;
    rd = hrdata_out;
  endtask
  // Main sequence: reset, table of waveform cases, then awkward cases.
  initial begin
    rows[0] = '{3'h2, 8'h09, 8'h00, 8'h31, 20, 10, 0, 0};
    rows[1] = '{3'h3, 8'h3F, 8'h00, 8'h3A, 256, 64, 256, 1};
    rows[2] = '{3'h3, 8'h3F, 8'hFF, 8'h3B, 256, 192, 0, 1};
    rows[3] = '{3'h7, 8'h13, 8'h08, 8'h39, 40, 20, 20, 9};
    rows[4] = '{3'h1, 8'h40, 8'h00, 8'h3A, 510, 128, 0, 0};
    rows[5] = '{3'h1, 8'h40, 8'hFF, 8'h3B, 510, 382, 0, 1};
    rows[6] = '{3'h5, 8'h63, 8'h28, 8'h78, 0, 1, 198, 80};
    rows[7] = '{3'h3, 8'h3F, 8'h28, 8'h0A, 0, 0, 0, 0};
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    chk({26'h0, wave_a_oe_n_out, wave_b_oe_n_out, wave_a_out, wave_b_out,
      hreadyout_out, hresp_out}, 32'h32);
    for (i = 0; i < 6; i = i + 1) begin
      bus(i * 4, 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    bus(8'h18, 1'b1, 32'hFFFFFFFF);
    bus(8'h18, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // Waveform table: stop, load compares and action, then run at full rate.
    for (i = 0; i < 8; i = i + 1) begin
      bus(`T8W_OFF_CTRL, 1'b1, 32'h0);
      bus(`T8W_OFF_CMPA, 1'b1, {24'h0, rows[i].ca});
      bus(`T8W_OFF_CMPB, 1'b1, {24'h0, rows[i].cb});
      bus(`T8W_OFF_COUNT, 1'b1, 32'h0);
      bus(`T8W_OFF_ACT, 1'b1, {24'h0, rows[i].act});
      bus(`T8W_OFF_CTRL, 1'b1, {28'h001, 1'b0, rows[i].m});
      repeat (600) @(posedge ref_clk_in);
      clr <= 1'b1;
      @(posedge ref_clk_in);
      clr <= 1'b0;
      repeat (1100) @(posedge ref_clk_in);
      chk({16'h0, per_a}, rows[i].pa);
      chk(rows[i].pa ? {16'h0, hi_a} : {31'h0, lvl_a}, rows[i].ha);
      chk({16'h0, per_b}, rows[i].pb);
      chk(rows[i].pb ? {16'h0, hi_b} : {31'h0, lvl_b}, rows[i].hb);
    end
    // Clear-on-match with the count already past compare A: wrap before match.
    bus(`T8W_OFF_CTRL, 1'b1, 32'h0);
    bus(`T8W_OFF_FLAGS, 1'b1, 32'h7);
    bus(`T8W_OFF_COUNT, 1'b1, 32'h50);
    bus(`T8W_OFF_CMPA, 1'b1, 32'h09);
    bus(`T8W_OFF_CTRL, 1'b1, 32'h12);
    repeat (100) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    repeat (100) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    bus(`T8W_OFF_CTRL, 1'b1, 32'h0);
    bus(`T8W_OFF_FLAGS, 1'b1, 32'h1);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h2);
    bus(`T8W_OFF_COUNT, 1'b0, 32'h0);
    chk({31'h0, rd <= 32'h9}, 32'h1);
    // Every divider above one and the oscillator source over a fixed run.
    for (i = 0; i < 7; i = i + 1) begin
      bus(`T8W_OFF_COUNT, 1'b1, 32'h0);
      bus(`T8W_OFF_CTRL, 1'b1, (i < 6) ? (i + 2) << 4 : 32'h120);
      repeat (1280) @(posedge ref_clk_in);
      bus(`T8W_OFF_CTRL, 1'b1, 32'h0);
      bus(`T8W_OFF_COUNT, 1'b0, 32'h0);
      chk({31'h0, rd + 1 >= pexp[i] && rd <= pexp[i] + 1}, 32'h1);
    end
    // Fast PWM: a compare A write after start waits for the top; B still matches at 0x28.
    bus(`T8W_OFF_COUNT, 1'b1, 32'h0);
    bus(`T8W_OFF_FLAGS, 1'b1, 32'h7);
    bus(`T8W_OFF_CMPA, 1'b1, 32'h3F);
    bus(`T8W_OFF_CTRL, 1'b1, 32'h13);
    repeat (10) @(posedge ref_clk_in);
    bus(`T8W_OFF_CMPA, 1'b1, 32'h05);
    repeat (60) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h6);
    repeat (200) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h7);
    // Phase correct from 0x80: no overflow at the ceiling, only at the bottom.
    bus(`T8W_OFF_CTRL, 1'b1, 32'h0);
    bus(`T8W_OFF_FLAGS, 1'b1, 32'h7);
    bus(`T8W_OFF_COUNT, 1'b1, 32'h80);
    bus(`T8W_OFF_CTRL, 1'b1, 32'h11);
    repeat (300) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    repeat (100) @(posedge ref_clk_in);
    bus(`T8W_OFF_FLAGS, 1'b0, 32'h0);
    chk(rd, 32'h7);
    test_done;
  end
endmodule
bind t8w_top t8w_monitor u_mon (.ref_clk_in, .reset_in, .osc_tick_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
  .hresp_out, .wave_a_out, .wave_a_oe_n_out, .wave_b_out, .wave_b_oe_n_out);
